//--- include/timer_pkg.sv
// Constants shared by the dual timer/counter control block.
// Assumes an 8-bit special function register port on the MPU side.
package timer_pkg;
    // Special function register addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_LOW0 = 8'h8A;
    localparam logic [7:0] ADDR_LOW1 = 8'h8B;
    localparam logic [7:0] ADDR_HIGH0 = 8'h8C;
    localparam logic [7:0] ADDR_HIGH1 = 8'h8D;

    // Reset values; the register contents are cleared at reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Bit positions of timer 0 fields; timer 1 sits one stride above.
    localparam int CTRL_TYPE_BIT = 0;
    localparam int CTRL_EXT_FLAG_BIT = 1;
    localparam int CTRL_RUN_BIT = 4;
    localparam int CTRL_OVF_BIT = 5;
    localparam int CTRL_IRQ_STRIDE = 2;
    localparam int CTRL_TIMER_STRIDE = 2;
    localparam int MODE_FIELD_LSB = 0;
    localparam int MODE_SELECT_BIT = 2;
    localparam int MODE_GATE_BIT = 3;
    localparam int MODE_TIMER_STRIDE = 4;

    // Operating mode field encodings.
    localparam logic [1:0] OPMODE_13BIT = 2'h0;
    localparam logic [1:0] OPMODE_16BIT = 2'h1;
    localparam logic [1:0] OPMODE_RELOAD = 2'h2;
    localparam logic [1:0] OPMODE_SPLIT = 2'h3;

    // One machine cycle is this many MPU clock periods.
    localparam int MACHINE_CYCLE_CLKS = 12;
endpackage : timer_pkg

//--- hdl/pin_filter.sv
// Three-stage synchroniser with an agreement filter for one pin.
// Assumes the pin is asynchronous to clk_sys_i and idles high.
module pin_filter (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic [2:0] shift;
        logic level;
    } filt_s;

    filt_s state_reg;
    filt_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.shift = {state_reg.shift[1:0], pin_i};
        // The first stage is only read by the second stage.
        if (state_reg.shift[1] == state_reg.shift[2]) begin
            state_next.level = state_reg.shift[2];
        end
    end

    // Idle-high reset value keeps a spurious falling edge from appearing.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg <= '{shift: 3'h7, level: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
endmodule : pin_filter

//--- hdl/dual_timer_counter_control.sv
// Two timer/counters with mode, control and flag registers on the SFR port.
// Assumes the MPU drives one SFR access per clock and acknowledges
// interrupt service with one-cycle pulses; pins are asynchronous.
//
// Notes on behaviour
// - Select bit one counts events; zero times only with gate clear.
// - Gate bit enables external control; run needed.
// - Gated counter increments on count pin falls.
// - Two-bit mode field per timer, each nibble.
// - Timer 1 overflow sets flag unless timer 0 is split; software/ack clear.
// - Timer 0 overflow sets flag; software/ack clear.
// - Timer 1 counts only while run bit set.
// - Timer 0 counts only while run bit set, except its split-mode high half.
// - Interrupt 1 falling edge sets flag; ack clears.
// - Interrupt 0 falling edge sets flag; ack clears.
// - Type bit one selects edge or level.
// - Type bit zero selects edge or level.
// - Type zero means low level, one falling edge.
// - Timer mode increments every twelve clocks.
// - Modes: 13-bit, 16-bit, 8-bit reload, split/stop.
// - Input falls recognised over two machine cycles.
module dual_timer_counter_control (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic count_input_zero_i,
    input wire logic count_input_one_i,
    input wire logic ext_irq_input_zero_i,
    input wire logic ext_irq_input_one_i,
    input wire logic [1:0] overflow_ack_i,
    input wire logic [1:0] ext_irq_ack_i,
    output logic [1:0] overflow_flag_o,
    output logic [1:0] ext_irq_flag_o
);
    typedef struct packed {
        logic [7:0] mode_reg;
        logic [7:0] ctrl_reg;
        logic [1:0][7:0] low_reg;
        logic [1:0][7:0] high_reg;
        logic [3:0] presc;
        logic [1:0] cnt_sample;
        logic [1:0] irq_prev;
        logic [7:0] rdata;
    } state_s;

    localparam logic [3:0] PRESC_LAST =
        4'(timer_pkg::MACHINE_CYCLE_CLKS - 1);

    state_s state_reg;
    state_s state_next;
    logic [1:0] cnt_level;
    logic [1:0] irq_level;

    pin_filter u_cnt0 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .pin_i(count_input_zero_i),
        .level_o(cnt_level[0])
    );
    pin_filter u_cnt1 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .pin_i(count_input_one_i),
        .level_o(cnt_level[1])
    );
    pin_filter u_irq0 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .pin_i(ext_irq_input_zero_i),
        .level_o(irq_level[0])
    );
    pin_filter u_irq1 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .pin_i(ext_irq_input_one_i),
        .level_o(irq_level[1])
    );

    // Returns {overflow, high, low} after one count in the given mode.
    function automatic logic [16:0] step(
        input logic [1:0] mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = 14'({hi, lo[4:0]}) + 14'h0001;
        c16 = 17'({hi, lo}) + 17'h0_0001;
        c8 = 9'(lo) + 9'h001;
        step = {1'b0, hi, lo};
        case (mode)
            timer_pkg::OPMODE_13BIT: begin
                // Upper three low-register bits are held at zero.
                step = {c13[13], c13[12:5], 3'h0, c13[4:0]};
            end
            timer_pkg::OPMODE_16BIT: begin
                step = c16;
            end
            timer_pkg::OPMODE_RELOAD: begin
                step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
            end
            default: begin
                step = {c8[8], hi, c8[7:0]};
            end
        endcase
    endfunction : step

    always_comb begin
        logic tick;
        logic [1:0] fall;
        logic [1:0] ovf_set;
        logic [1:0] irq_set;
        logic [1:0] mode;
        logic gate;
        logic sel;
        logic run;
        logic evt;
        logic [16:0] res;
        logic [8:0] hi8;
        logic [7:0] base;
        tick = 1'b0;
        fall = 2'h0;
        ovf_set = 2'h0;
        irq_set = 2'h0;
        mode = 2'h0;
        gate = 1'b0;
        sel = 1'b0;
        run = 1'b0;
        evt = 1'b0;
        res = 17'h0_0000;
        hi8 = 9'h000;
        base = 8'h00;
        state_next = state_reg;

        tick = (state_reg.presc == PRESC_LAST);
        state_next.presc = tick ? 4'h0 : state_reg.presc + 4'h1;
        // Count pins are sampled once per machine cycle, so a fall needs a
        // high sample then a low one: at most half the sampling rate.
        if (tick) begin
            state_next.cnt_sample = cnt_level;
        end
        fall = {2{tick}} & state_reg.cnt_sample & ~cnt_level;

        for (int i = 0; i < 2; i++) begin
            mode = state_reg.mode_reg[timer_pkg::MODE_FIELD_LSB
                + i * timer_pkg::MODE_TIMER_STRIDE +: 2];
            sel = state_reg.mode_reg[timer_pkg::MODE_SELECT_BIT
                + i * timer_pkg::MODE_TIMER_STRIDE];
            gate = state_reg.mode_reg[timer_pkg::MODE_GATE_BIT
                + i * timer_pkg::MODE_TIMER_STRIDE];
            run = state_reg.ctrl_reg[timer_pkg::CTRL_RUN_BIT
                + i * timer_pkg::CTRL_TIMER_STRIDE];
            // The gate hands control to the interrupt pin level.
            run = run & (~gate | irq_level[i]);
            evt = (sel | gate) ? fall[i] : tick;
            // Timer 1 stops in split mode.
            if (run && evt && !(i == 1 && mode == timer_pkg::OPMODE_SPLIT)) begin
                res = step(mode, state_reg.low_reg[i],
                    state_reg.high_reg[i]);
                state_next.low_reg[i] = res[7:0];
                state_next.high_reg[i] = res[15:8];
                ovf_set[i] = res[16];
            end
        end

        // In split mode the high half of timer 0 runs on timer 1's run
        // bit and takes timer 1's flag, so timer 1 loses its flag.
        if (state_reg.mode_reg[timer_pkg::MODE_FIELD_LSB +: 2]
            == timer_pkg::OPMODE_SPLIT) begin
            ovf_set[1] = 1'b0;
            if (tick && state_reg.ctrl_reg[timer_pkg::CTRL_RUN_BIT
                + timer_pkg::CTRL_TIMER_STRIDE]) begin
                hi8 = 9'(state_reg.high_reg[0]) + 9'h001;
                state_next.high_reg[0] = hi8[7:0];
                ovf_set[1] = hi8[8];
            end
        end

        // Type 1 latches on a falling edge; type 0 follows a low level.
        state_next.irq_prev = irq_level;
        for (int i = 0; i < 2; i++) begin
            if (state_reg.ctrl_reg[timer_pkg::CTRL_TYPE_BIT
                + i * timer_pkg::CTRL_IRQ_STRIDE]) begin
                irq_set[i] = state_reg.irq_prev[i] & ~irq_level[i];
            end else begin
                irq_set[i] = ~irq_level[i];
            end
        end

        // Software writes win over counting on the count registers.
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                timer_pkg::ADDR_MODE: state_next.mode_reg = sfr_wdata_i;
                timer_pkg::ADDR_LOW0: state_next.low_reg[0] = sfr_wdata_i;
                timer_pkg::ADDR_LOW1: state_next.low_reg[1] = sfr_wdata_i;
                timer_pkg::ADDR_HIGH0: state_next.high_reg[0] = sfr_wdata_i;
                timer_pkg::ADDR_HIGH1: state_next.high_reg[1] = sfr_wdata_i;
                default: begin
                end
            endcase
        end

        // Flags: a hardware set wins over a software write or an ack.
        base = (sfr_wr_i && sfr_addr_i == timer_pkg::ADDR_CTRL)
            ? sfr_wdata_i : state_reg.ctrl_reg;
        state_next.ctrl_reg = base;
        for (int i = 0; i < 2; i++) begin
            state_next.ctrl_reg[timer_pkg::CTRL_OVF_BIT
                + i * timer_pkg::CTRL_TIMER_STRIDE] = ovf_set[i]
                | (base[timer_pkg::CTRL_OVF_BIT
                + i * timer_pkg::CTRL_TIMER_STRIDE]
                & ~overflow_ack_i[i]);
            state_next.ctrl_reg[timer_pkg::CTRL_EXT_FLAG_BIT
                + i * timer_pkg::CTRL_IRQ_STRIDE] = irq_set[i]
                | (base[timer_pkg::CTRL_EXT_FLAG_BIT
                + i * timer_pkg::CTRL_IRQ_STRIDE]
                & ~ext_irq_ack_i[i]);
        end

        if (sfr_rd_i) begin
            case (sfr_addr_i)
                timer_pkg::ADDR_CTRL: state_next.rdata = state_reg.ctrl_reg;
                timer_pkg::ADDR_MODE: state_next.rdata = state_reg.mode_reg;
                timer_pkg::ADDR_LOW0: state_next.rdata = state_reg.low_reg[0];
                timer_pkg::ADDR_LOW1: state_next.rdata = state_reg.low_reg[1];
                timer_pkg::ADDR_HIGH0: state_next.rdata = state_reg.high_reg[0];
                timer_pkg::ADDR_HIGH1: state_next.rdata = state_reg.high_reg[1];
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg.mode_reg <= timer_pkg::MODE_RESET;
            state_reg.ctrl_reg <= timer_pkg::CTRL_RESET;
            state_reg.low_reg <= {2{timer_pkg::COUNT_RESET}};
            state_reg.high_reg <= {2{timer_pkg::COUNT_RESET}};
            state_reg.presc <= 4'h0;
            state_reg.cnt_sample <= 2'h3;
            state_reg.irq_prev <= 2'h3;
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata_o = state_reg.rdata;
    assign overflow_flag_o = {
        state_reg.ctrl_reg[timer_pkg::CTRL_OVF_BIT
            + timer_pkg::CTRL_TIMER_STRIDE],
        state_reg.ctrl_reg[timer_pkg::CTRL_OVF_BIT]};
    assign ext_irq_flag_o = {
        state_reg.ctrl_reg[timer_pkg::CTRL_EXT_FLAG_BIT
            + timer_pkg::CTRL_IRQ_STRIDE],
        state_reg.ctrl_reg[timer_pkg::CTRL_EXT_FLAG_BIT]};
endmodule : dual_timer_counter_control

//--- verif/dtc_checker_sva.sv
// Port-level checker for the dual timer/counter control block.
// Assumes run and type bits change only through writes to the ctrl SFR.
module dtc_checker (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic count_input_zero_i,
    input wire logic count_input_one_i,
    input wire logic ext_irq_input_zero_i,
    input wire logic ext_irq_input_one_i,
    input wire logic [1:0] overflow_ack_i,
    input wire logic [1:0] ext_irq_ack_i,
    input wire logic [1:0] overflow_flag_o,
    input wire logic [1:0] ext_irq_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] run_q;
    logic [1:0] type_q;
    logic cwr;
    assign cwr = sfr_wr_i && sfr_addr_i == timer_pkg::ADDR_CTRL;
    // Shadow of the run and type bits, since the checker sees only ports.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            run_q <= 2'h0;
            type_q <= 2'h0;
        end else if (cwr) begin
            run_q <= {sfr_wdata_i[6], sfr_wdata_i[4]};
            type_q <= {sfr_wdata_i[2], sfr_wdata_i[0]};
        end
    end
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    a_mode_readback: assert property (
        sfr_wr_i && sfr_addr_i == timer_pkg::ADDR_MODE ##1 !sfr_wr_i
        ##1 sfr_rd_i && sfr_addr_i == timer_pkg::ADDR_MODE
        |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("mode readback");
    a_flags_in_ctrl: assert property (
        sfr_rd_i && sfr_addr_i == timer_pkg::ADDR_CTRL |=>
        {sfr_rdata_o[7], sfr_rdata_o[5], sfr_rdata_o[3], sfr_rdata_o[1]}
        == $past({overflow_flag_o, ext_irq_flag_o})) else $error("ctrl flags");
    a_halt_no_ovf0: assert property (
        !run_q[0] && !cwr |=> !$rose(overflow_flag_o[0]))
        else $error("flag 0 rose while halted");
    a_halt_no_ovf1: assert property (
        !run_q[1] && !cwr |=> !$rose(overflow_flag_o[1]))
        else $error("flag 1 rose while halted");
    a_ack_clears_ovf0: assert property (
        overflow_ack_i[0] && !run_q[0] && !cwr |=> !overflow_flag_o[0])
        else $error("flag 0 kept after ack");
    a_ack_clears_ovf1: assert property (
        overflow_ack_i[1] && !run_q[1] && !cwr |=> !overflow_flag_o[1])
        else $error("flag 1 kept after ack");
    a_level_keeps_irq1: assert property (
        (!type_q[1] && !ext_irq_input_one_i)[*8] |=> ext_irq_flag_o[1])
        else $error("low level on irq 1 not flagged");
    a_edge_ack_irq0: assert property (
        (type_q[0] && ext_irq_input_zero_i
        && $past(ext_irq_input_zero_i, 6))[*8] ##0 ext_irq_ack_i[0] && !cwr
        |=> !ext_irq_flag_o[0]) else $error("irq 0 flag kept after ack");
    a_quiet_pin_irq1: assert property (
        (ext_irq_input_one_i && $past(ext_irq_input_one_i, 6) && !cwr)[*8]
        |=> !$rose(ext_irq_flag_o[1])) else $error("irq 1 rose on quiet pin");
    c_ovf0: cover property ($rose(overflow_flag_o[0]));
    c_ovf1: cover property ($rose(overflow_flag_o[1]));
    c_irq1: cover property ($rose(ext_irq_flag_o[1]));
endmodule : dtc_checker

bind dual_timer_counter_control dtc_checker u_chk (.clk_sys_i, .reset_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .count_input_zero_i, .count_input_one_i, .ext_irq_input_zero_i,
    .ext_irq_input_one_i, .overflow_ack_i, .ext_irq_ack_i, .overflow_flag_o,
    .ext_irq_flag_o);

//--- verif/count_pin_model.sv
// Behavioural model of one I/O pin feeding a count or interrupt input.
// Assumes the pin idles high through a pull-up, as the filters expect.
module count_pin_model (
    input wire logic clk_sys_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_o = 1'b1;
    // Each level stands two machine cycles so no fall is missed.
    task automatic fall(input int n);
        repeat (n) begin
            repeat (24) @(negedge clk_sys_i);
            pin_o = 1'b0;
            repeat (24) @(negedge clk_sys_i);
            pin_o = 1'b1;
        end
    endtask : fall
    task automatic hold(input logic lvl);
        @(negedge clk_sys_i);
        pin_o = lvl;
    endtask : hold
endmodule : count_pin_model

//--- verif/tb_top.sv
// Self-checking bench for the dual timer/counter control block.
// Assumes pin models idle high; SFR strobes change at falling edges.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i;
    logic reset_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    logic [7:0] sfr_addr_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic [1:0] overflow_ack_i;
    logic [1:0] ext_irq_ack_i;
    logic [1:0] overflow_flag_o;
    logic [1:0] ext_irq_flag_o;
    logic count_input_zero_i, count_input_one_i;
    logic ext_irq_input_zero_i, ext_irq_input_one_i;
    logic [7:0] v;
    logic [7:0] w;
    int fails = 0;
    int n_tests = 0;
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    count_pin_model u_c0 (.clk_sys_i, .pin_o(count_input_zero_i));
    count_pin_model u_c1 (.clk_sys_i, .pin_o(count_input_one_i));
    count_pin_model u_e0 (.clk_sys_i, .pin_o(ext_irq_input_zero_i));
    count_pin_model u_e1 (.clk_sys_i, .pin_o(ext_irq_input_one_i));
    dual_timer_counter_control u_dut (.clk_sys_i, .reset_i, .sfr_addr_i,
        .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .count_input_zero_i,
        .count_input_one_i, .ext_irq_input_zero_i, .ext_irq_input_one_i,
        .overflow_ack_i, .ext_irq_ack_i, .overflow_flag_o, .ext_irq_flag_o);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_rd_i = 1'b0;
        v = sfr_rdata_o;
    endtask : rd
    task automatic ack(input logic [1:0] o, input logic [1:0] e);
        @(negedge clk_sys_i);
        overflow_ack_i = o;
        ext_irq_ack_i = e;
        @(negedge clk_sys_i);
        overflow_ack_i = 2'h0;
        ext_irq_ack_i = 2'h0;
    endtask : ack
    task automatic wait_ovf(input int b);
        for (int i = 0; i < 100 && overflow_flag_o[b] !== 1'b1; i++) begin
            @(negedge clk_sys_i);
        end
        // A flag that never comes is a mismatch, not a silent pass.
        if (overflow_flag_o[b] !== 1'b1) begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time,
                overflow_flag_o[b], 1'b1);
        end
    endtask : wait_ovf
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        fails++;
        print_verdict;
    end
    initial begin
        reset_i = 1'b1;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        overflow_ack_i = 2'h0;
        ext_irq_ack_i = 2'h0;
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        reset_i = 1'b0;
        for (int a = 'h88; a <= 'h8d; a++) begin
            rd(a[7:0]);
            chk(v, 8'h00);
        end
        wr(8'h90, 8'hff);
        rd(8'h90);
        chk(v, 8'h00);
        wr(8'h89, 8'ha5);
        rd(8'h89);
        chk(v, 8'ha5);
        $display("test regs done");
        wr(8'h89, 8'h01);
        wr(8'h88, 8'h10);
        repeat (240) @(negedge clk_sys_i);
        wr(8'h88, 8'h00);
        rd(8'h8a);
        w = v;
        chk({7'h00, v >= 8'h14 && v <= 8'h15}, 8'h01);
        repeat (48) @(negedge clk_sys_i);
        rd(8'h8a);
        chk(v, w);
        rd(8'h8b);
        chk(v, 8'h00);
        $display("test rate done");
        wr(8'h8c, 8'hff);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        wait_ovf(0);
        wr(8'h88, 8'h20);
        rd(8'h8c);
        chk(v, 8'h00);
        rd(8'h88);
        chk(v, 8'h20);
        ack(2'h3, 2'h0);
        chk({6'h00, overflow_flag_o}, 8'h00);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'hff);
        wr(8'h88, 8'h40);
        wait_ovf(1);
        wr(8'h88, 8'h00);
        rd(8'h88);
        chk(v, 8'h00);
        rd(8'h8b);
        chk(v & 8'he0, 8'h00);
        rd(8'h8d);
        chk(v, 8'h00);
        wr(8'h89, 8'h02);
        wr(8'h8c, 8'hf0);
        wr(8'h8a, 8'hff);
        wr(8'h88, 8'h10);
        wait_ovf(0);
        wr(8'h88, 8'h00);
        rd(8'h8c);
        chk(v, 8'hf0);
        rd(8'h8a);
        chk(v & 8'hfe, 8'hf0);
        wr(8'h89, 8'h30);
        wr(8'h8b, 8'h00);
        wr(8'h88, 8'h40);
        repeat (60) @(negedge clk_sys_i);
        wr(8'h88, 8'h00);
        rd(8'h8b);
        chk(v, 8'h00);
        $display("test modes done");
        wr(8'h89, 8'h55);
        for (int a = 'h8a; a <= 'h8d; a++) wr(a[7:0], 8'h00);
        wr(8'h88, 8'h50);
        u_c0.fall(3);
        u_c1.fall(2);
        rd(8'h8a);
        chk(v, 8'h03);
        rd(8'h8b);
        chk(v, 8'h02);
        wr(8'h89, 8'h09);
        wr(8'h8a, 8'h00);
        u_c0.fall(2);
        rd(8'h8a);
        chk(v, 8'h02);
        u_e0.hold(1'b0);
        u_c0.fall(2);
        rd(8'h8a);
        chk(v, 8'h02);
        u_e0.hold(1'b1);
        $display("test counters done");
        wr(8'h88, 8'h00);
        repeat (10) @(negedge clk_sys_i);
        ack(2'h0, 2'h3);
        chk({6'h00, ext_irq_flag_o}, 8'h00);
        u_e1.hold(1'b0);
        repeat (20) @(negedge clk_sys_i);
        ack(2'h0, 2'h2);
        chk({6'h00, ext_irq_flag_o}, 8'h02);
        u_e1.hold(1'b1);
        repeat (10) @(negedge clk_sys_i);
        ack(2'h0, 2'h2);
        chk({6'h00, ext_irq_flag_o}, 8'h00);
        wr(8'h88, 8'h05);
        u_e0.fall(1);
        u_e1.fall(1);
        chk({6'h00, ext_irq_flag_o}, 8'h03);
        ack(2'h0, 2'h3);
        chk({6'h00, ext_irq_flag_o}, 8'h00);
        u_e0.hold(1'b0);
        repeat (20) @(negedge clk_sys_i);
        ack(2'h0, 2'h1);
        chk({6'h00, ext_irq_flag_o}, 8'h00);
        u_e0.hold(1'b1);
        $display("test irqs done");
        // A reset with the type bits set must bring ctrl, mode and the timer 0 low register back to zero.
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        reset_i = 1'b0;
        rd(8'h88);
        chk(v, 8'h00);
        rd(8'h89);
        chk(v, 8'h00);
        rd(8'h8a);
        chk(v, 8'h00);
        $display("test reset done");
        print_verdict;
    end
endmodule : tb_top
